// file: core/phc_pkg.sv
/*
 holds offsets, field positions, reset values, states and carriers
 for the holdover control block. assumes a single system clock.
*/
package phc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_EXIT_CFG = 8'h16; // holdover_exit_config
  localparam logic [7:0] ADDR_REF_MODE = 8'h29; // reference_mode_config
  localparam logic [7:0] ADDR_RSVD = 8'hA5; // reserved_must_write
  // ----------------------------------------
  // field positions and resets
  // ----------------------------------------
  localparam int CRIT_LSB = 0; // exit criteria [1:0]
  localparam int ACT_LSB = 2; // exit action [3:2]
  localparam int VAL_LSB = 4; // validation timer setting [6:4]
  localparam int USE_DAC_BIT = 2; // holdover uses dac
  localparam logic [7:0] EXIT_CFG_RST = 8'h00;
  localparam logic [7:0] REF_MODE_RST = 8'h00;
  localparam logic [7:0] RSVD_RST = 8'h00;
  // ----------------------------------------
  // encodings and timing counts
  // ----------------------------------------
  localparam logic [1:0] CRIT_LOS = 2'h0; // reference present only
  localparam logic [1:0] CRIT_PHASE = 2'h1; // plus zero phase error
  localparam logic [1:0] ACT_NONE = 2'h1; // no divider reset
  localparam logic [1:0] ACT_DAC = 2'h3; // dac assisted release
  localparam int LCM_DIV = 4; // system cycles per common divided clock tick
  localparam int VAL_EXPIRIES = 3; // expiries before the flag clears
  localparam int RAMP_TICKS = 16; // ticks per dac impedance step
  localparam int ADC_BITS = 7;
  localparam int AVG_SHIFT = 4; // low-pass filter depth
  // fsm states, gray along the usual path
  typedef enum logic [2:0] {
    PHC_ACQ = 3'h0,
    PHC_LOCKED = 3'h1,
    PHC_HOLD = 3'h3,
    PHC_SLIP = 3'h2,
    PHC_DIVRST = 3'h6,
    PHC_DACREL = 3'h7
  } phc_state_e;
  // analog control carrier
  typedef struct packed {
    logic cp_tristate;
    logic dac_force;
    logic [2:0] dac_impedance;
    logic divider_reset;
  } phc_analog_s;
endpackage

// file: core/phc_holdover_ctrl.sv
/*
 holdover steady state and exit control for the first loop.
 assumes lock detect, phase error, cycle slip and adc code come from
 logic on clk_sys; the raw reference-missing level comes from a pin.
*/
`timescale 1ns/1ps
// How it works
// - holdover tristates pump, dac forces when enabled
// - dac value is filtered adc while locked
// - adc and dac codes are seven bits
// - two 2-bit exit fields in one register
// - criteria 1 action 1: wait phase, no reset
// - criteria 0 action 0: reset dividers on return
// - criteria 0 action 3: reset then dac release
// - zero phase mode waits slip, pump tristated
// - divider reset restarts immediately, no crossing wait
// - dac release: pump on, impedance ramps up
// - all timing counts common divided clock ticks
// - locked enters holdover on loss events
// - missing flag held three validation expiries
module phc_holdover_ctrl
  import phc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reg_wr, // register write strobe
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata, // registered read data
  input wire logic ref_missing_pin, // raw reference loss level
  input wire logic lock_detect, // lock detector output
  input wire logic loss_of_lock, // lock lost event
  input wire logic ref_switch, // priority driven switch request
  input wire logic phase_error_low,
  input wire logic cycle_slip, // slip indication at detector
  input wire logic [ADC_BITS-1:0] adc_code, // tuning voltage sense
  output phc_analog_s analog, // pump, dac and divider controls
  output logic [ADC_BITS-1:0] dac_code, // held tuning value
  output logic reference_missing_flag,
  output logic [2:0] fsm_state
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] exit_cfg; // criteria, action, validation setting
  logic [7:0] ref_mode; // bit 2 selects dac holdover
  logic [7:0] rsvd; // stored only
  wire logic [1:0] crit = exit_cfg[CRIT_LSB +: 2];
  wire logic [1:0] act = exit_cfg[ACT_LSB +: 2];
  wire logic [2:0] val_set = exit_cfg[VAL_LSB +: 3];
  wire logic use_dac = ref_mode[USE_DAC_BIT];
  wire logic [7:0] next_rdata = (reg_addr == ADDR_EXIT_CFG) ? exit_cfg :
                                (reg_addr == ADDR_REF_MODE) ? ref_mode :
                                (reg_addr == ADDR_RSVD) ? rsvd : 8'h00;
  // software writes; read data lags the address by one cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      exit_cfg <= EXIT_CFG_RST;
      ref_mode <= REF_MODE_RST;
      rsvd <= RSVD_RST;
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
      if (reg_wr && reg_addr == ADDR_EXIT_CFG) exit_cfg <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_REF_MODE) ref_mode <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_RSVD) rsvd <= reg_wdata;
    end
  end
  // ----------------------------------------
  // common divided clock enable
  // ----------------------------------------
  logic [7:0] lcm_cnt; // divider count
  logic lcm_tick; // one-cycle enable pulse
  wire logic lcm_wrap = (lcm_cnt == 8'(LCM_DIV - 1));
  // every slow timer below steps only on this pulse
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lcm_cnt <= 8'h00;
      lcm_tick <= 1'b0;
    end else begin
      lcm_cnt <= lcm_wrap ? 8'h00 : lcm_cnt + 8'h01;
      lcm_tick <= lcm_wrap;
    end
  end
  // ----------------------------------------
  // reference-missing synchroniser and validation
  // ----------------------------------------
  logic [2:0] miss_sync; // [0] feeds only [1]
  logic [6:0] val_cnt; // validation timer
  logic [1:0] expiries; // timer expiries while reference present
  wire logic miss_stable = miss_sync[1] == miss_sync[2];
  wire logic ref_present = miss_stable && !miss_sync[2];
  wire logic [6:0] val_len = (val_set == 3'h0) ? 7'h00 : 7'(7'h01 << (val_set - 3'h1));
  wire logic val_expire = lcm_tick && (val_cnt >= val_len);
  // flag rises at once, falls after enough expiries of the timer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      miss_sync <= 3'h7;
      val_cnt <= 7'h00;
      expiries <= 2'h0;
      reference_missing_flag <= 1'b1;
    end else begin
      miss_sync <= {miss_sync[1:0], ref_missing_pin};
      if (!ref_present) begin
        val_cnt <= 7'h00; // restart timer on any loss
        expiries <= 2'h0;
        if (miss_stable) reference_missing_flag <= 1'b1;
      end else if (lcm_tick) begin
        val_cnt <= val_expire ? 7'h00 : val_cnt + 7'h01;
        if (val_expire && expiries != 2'(VAL_EXPIRIES)) expiries <= expiries + 2'h1;
        if (expiries == 2'(VAL_EXPIRIES)) reference_missing_flag <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // tuning voltage averaging
  // ----------------------------------------
  logic [ADC_BITS+AVG_SHIFT-1:0] avg; // filter accumulator
  phc_state_e state;
  wire logic [ADC_BITS+AVG_SHIFT-1:0] avg_step = avg - (avg >> AVG_SHIFT)
    + {{AVG_SHIFT{1'b0}}, adc_code};
  // tracks only while locked so holdover holds the last good value
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avg <= '0;
      dac_code <= '0;
    end else begin
      if (lcm_tick && state == PHC_LOCKED && lock_detect) avg <= avg_step;
      dac_code <= avg[ADC_BITS+AVG_SHIFT-1 -: ADC_BITS];
    end
  end
  // ----------------------------------------
  // holdover state machine
  // ----------------------------------------
  logic [7:0] ramp_cnt; // ticks within one impedance step
  logic [2:0] imp; // dac impedance, 0 is lowest
  phc_state_e next_state;
  wire logic enter_hold = loss_of_lock || ref_switch || reference_missing_flag;
  wire logic ramp_step = lcm_tick && ramp_cnt == 8'(RAMP_TICKS - 1);
  wire logic exit_ready = !reference_missing_flag;
  // chooses the exit path from the two fields
  wire phc_state_e exit_target = (crit == CRIT_PHASE) ? PHC_SLIP :
                                 (act == ACT_NONE) ? PHC_ACQ : PHC_DIVRST;
  always_comb begin
    next_state = state;
    case (state)
      PHC_ACQ: if (lock_detect) next_state = PHC_LOCKED;
      PHC_LOCKED: if (enter_hold) next_state = PHC_HOLD;
      PHC_HOLD: if (exit_ready) next_state = exit_target;
      PHC_SLIP: begin
        // pump stays off until the phases cross
        if (reference_missing_flag) next_state = PHC_HOLD;
        else if (cycle_slip && phase_error_low) begin
          next_state = (act == ACT_NONE) ? PHC_ACQ : PHC_DIVRST;
        end
      end
      PHC_DIVRST: begin
        // one-cycle reset pulse, restart without waiting
        next_state = (act == ACT_DAC && use_dac) ? PHC_DACREL : PHC_ACQ;
      end
      PHC_DACREL: if (ramp_step && imp == 3'h7) next_state = PHC_ACQ;
      default: next_state = PHC_ACQ;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= PHC_ACQ;
      ramp_cnt <= 8'h00;
      imp <= 3'h0;
    end else begin
      state <= next_state;
      if (state != PHC_DACREL) begin
        ramp_cnt <= 8'h00;
        imp <= 3'h0; // low impedance lets the dac win first
      end else if (lcm_tick) begin
        ramp_cnt <= ramp_step ? 8'h00 : ramp_cnt + 8'h01;
        if (ramp_step && imp != 3'h7) imp <= imp + 3'h1;
      end
    end
  end
  // ----------------------------------------
  // analog controls, all registered
  // ----------------------------------------
  wire logic in_hold = next_state == PHC_HOLD || next_state == PHC_SLIP
                       || next_state == PHC_DIVRST;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      analog <= '0;
      fsm_state <= 3'h0;
    end else begin
      analog.cp_tristate <= in_hold;
      analog.dac_force <= use_dac && (in_hold || next_state == PHC_DACREL);
      analog.divider_reset <= next_state == PHC_DIVRST;
      analog.dac_impedance <= imp;
      fsm_state <= next_state;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_hold_tristate;
    @(posedge clk_sys) disable iff (reset)
      state == PHC_HOLD |-> analog.cp_tristate;
  endproperty
  a_hold_tristate: assert property (p_hold_tristate) else $error("pump not tristated");
  property p_dac_force;
    @(posedge clk_sys) disable iff (reset)
      // the force bit was registered with the enable of the cycle before
      state == PHC_HOLD |-> analog.dac_force == $past(use_dac);
  endproperty
  a_dac_force: assert property (p_dac_force) else $error("dac not forcing");
  property p_avg_frozen;
    @(posedge clk_sys) disable iff (reset)
      state == PHC_HOLD |=> $stable(avg);
  endproperty
  a_avg_frozen: assert property (p_avg_frozen) else $error("average moved in holdover");
  property p_enter_hold;
    @(posedge clk_sys) disable iff (reset)
      (state == PHC_LOCKED && loss_of_lock) |=> state == PHC_HOLD && analog.cp_tristate;
  endproperty
  a_enter_hold: assert property (p_enter_hold) else $error("no holdover on lock loss");
  property p_zpe_wait;
    @(posedge clk_sys) disable iff (reset)
      (state == PHC_SLIP && !cycle_slip) |=> state != PHC_ACQ && state != PHC_DIVRST;
  endproperty
  a_zpe_wait: assert property (p_zpe_wait) else $error("left before slip");
  sequence s_divrst;
    // pulse stands with the state, then both drop together
    state == PHC_DIVRST && analog.divider_reset ##1 state == PHC_ACQ && !analog.divider_reset;
  endsequence
  property p_div_reset;
    @(posedge clk_sys) disable iff (reset)
      (state == PHC_HOLD && exit_ready && crit == CRIT_LOS && act == 2'h0)
      |=> s_divrst;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider reset exit wrong");
  property p_dac_rel;
    @(posedge clk_sys) disable iff (reset)
      (state == PHC_DIVRST && act == ACT_DAC && use_dac) |=> state == PHC_DACREL
      ##1 (!analog.cp_tristate && analog.dac_impedance == 3'h0);
  endproperty
  a_dac_rel: assert property (p_dac_rel) else $error("dac release start wrong");
  property p_flag_held;
    @(posedge clk_sys) disable iff (reset)
      $fell(reference_missing_flag) |-> expiries == 2'(VAL_EXPIRIES);
  endproperty
  a_flag_held: assert property (p_flag_held) else $error("flag cleared early");
  property p_relock;
    @(posedge clk_sys) disable iff (reset)
      (state == PHC_ACQ && lock_detect) |=> state == PHC_LOCKED;
  endproperty
  a_relock: assert property (p_relock) else $error("no relock");
endmodule

// file: sim/phc_ref_model.sv
/*
 far side model: reference, vcxo and loop filter.
 assumes the bench steers reference loss and slip events.
*/
`timescale 1ns/1ps
module phc_ref_model
  import phc_pkg::*;
#(
  parameter int LOCK_CNT = 40 // lock threshold in clk_sys cycles
)(
  input wire logic clk_sys,
  input wire logic ref_lost, // bench: reference removed
  input wire logic slip_req, // bench: phases cross now
  input wire logic cp_tristate, // loop open while high
  output logic ref_missing_pin,
  output logic lock_detect,
  output logic phase_error_low,
  output logic cycle_slip,
  output logic [ADC_BITS-1:0] adc_code
);
  int cnt = 0; // closed-loop cycles with low phase error
  // pins taken as set up for reference use: buffer and path enabled,
  // no sync, vco or oscillator drive sharing them
  assign ref_missing_pin = ref_lost;
  assign phase_error_low = !ref_lost;
  // a slip needs a reference to slip against
  assign cycle_slip = slip_req && !ref_lost;
  assign adc_code = 7'h55; // steady tuning voltage
  assign lock_detect = (cnt >= LOCK_CNT);
  // lock counter, cleared whenever the loop is open
  always @(posedge clk_sys) begin
    if (ref_lost || cp_tristate) begin
      cnt <= 0;
    end else if (cnt < LOCK_CNT) begin
      cnt <= cnt + 1;
    end
  end
endmodule

// file: sim/testbench.sv
/*
 self-checking bench for the holdover control block.
 assumes the far side model in phc_ref_model.sv.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench
  import phc_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_sys = 0;
  logic reset = 1;
  logic reg_wr = 0; // write strobe
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic ref_lost = 0; // model commands
  logic slip_req = 0;
  logic loss_of_lock = 0;
  logic ref_switch = 0;
  logic ref_missing_pin, lock_detect, phase_error_low, cycle_slip;
  logic [ADC_BITS-1:0] adc_code, dac_code;
  phc_analog_s analog;
  logic reference_missing_flag;
  logic [2:0] fsm_state;
  logic [7:0] seen = 8'h00; // states visited in one exit
  logic rec_clr = 0; // restarts the path recorder
  int n_rst = 0; // divider reset pulses
  logic [2:0] imp_max = 3'h0; // top dac impedance step
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #20 clk_sys = ~clk_sys;
  phc_holdover_ctrl phc_holdover_ctrl_i (.clk_sys(clk_sys), .reset(reset),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ref_missing_pin(ref_missing_pin), .lock_detect(lock_detect),
    .loss_of_lock(loss_of_lock), .ref_switch(ref_switch), .phase_error_low(phase_error_low),
    .cycle_slip(cycle_slip), .adc_code(adc_code), .analog(analog), .dac_code(dac_code),
    .reference_missing_flag(reference_missing_flag), .fsm_state(fsm_state));
  phc_ref_model phc_ref_model_i (.clk_sys(clk_sys), .ref_lost(ref_lost),
    .slip_req(slip_req), .cp_tristate(analog.cp_tristate),
    .ref_missing_pin(ref_missing_pin), .lock_detect(lock_detect),
    .phase_error_low(phase_error_low), .cycle_slip(cycle_slip), .adc_code(adc_code));
  // watchdog plus path recorder; short pulses are missed by polling
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      end_of_test();
    end
    if (rec_clr) begin
      seen <= 8'h00;
      n_rst <= 0;
      imp_max <= 3'h0;
    end else if (!reset) begin
      seen[fsm_state] <= 1'b1;
      if (analog.divider_reset) n_rst <= n_rst + 1;
      if (analog.dac_impedance > imp_max) imp_max <= analog.dac_impedance;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 0;
  endtask
  // read data is registered, so look two cycles later
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(negedge clk_sys);
    reg_addr = a;
    repeat (2) @(negedge clk_sys);
    `CHK("reg_rdata", ex, reg_rdata)
  endtask
  // bounded poll of the state output
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (fsm_state !== s && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("fsm_state", s, fsm_state)
  endtask
  // enter holdover one way, leave by the configured method
  task automatic exit_run(input logic [7:0] cfg, input logic [7:0] mode, input int how,
      input logic [7:0] ex_seen, input int ex_rst);
    int n;
    int lo;
    wr(ADDR_EXIT_CFG, cfg);
    wr(ADDR_REF_MODE, mode);
    wait_st(PHC_LOCKED);
    rec_clr = 1; // recorder restarts from the locked state
    @(negedge clk_sys);
    rec_clr = 0;
    ref_lost = (how == 0);
    ref_switch = (how == 1);
    loss_of_lock = (how == 2);
    wait_st(PHC_HOLD);
    `CHK("cp_tristate", 1'b1, analog.cp_tristate)
    `CHK("dac_force", mode[USE_DAC_BIT], analog.dac_force)
    ref_switch = 0;
    loss_of_lock = 0;
    if (how == 0) begin
      repeat (50) @(negedge clk_sys);
      `CHK("flag", 1'b1, reference_missing_flag)
      ref_lost = 0;
      repeat (5) @(negedge clk_sys);
      `CHK("flag", 1'b1, reference_missing_flag)
      n = 5;
      while (reference_missing_flag && n < 400) begin
        @(negedge clk_sys);
        n++;
      end
      // setting 1: two ticks per expiry, one more tick clears; 3 sync
      // cycles and up to LCM_DIV before the first tick
      lo = 4 + 2 * VAL_EXPIRIES * LCM_DIV;
      `CHK("flag clear time", 1'b1, n >= lo && n < lo + LCM_DIV)
    end
    if (ex_seen[6]) begin
      wait_st(PHC_DIVRST);
      `CHK("divider_reset", 1'b1, analog.divider_reset)
    end
    if (ex_seen[2]) begin
      wait_st(PHC_SLIP);
      repeat (20) @(negedge clk_sys);
      `CHK("slip wait", {1'b1, PHC_SLIP}, {analog.cp_tristate, fsm_state})
      slip_req = 1;
      @(negedge clk_sys);
      slip_req = 0;
    end
    if (ex_seen[7]) begin
      wait_st(PHC_DACREL);
      `CHK("release", 2'b01, {analog.cp_tristate, analog.dac_force})
    end
    wait_st(PHC_LOCKED);
    `CHK("path", ex_seen, seen)
    `CHK("div resets", ex_rst, n_rst)
    if (ex_seen[7]) `CHK("impedance", 3'h7, imp_max)
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge clk_sys);
    `CHK("reset outs", 4'h8, {reference_missing_flag, fsm_state})
    `CHK("reset analog", 5'h00, analog)
    reset = 0;
    rd(ADDR_EXIT_CFG, EXIT_CFG_RST);
    rd(ADDR_REF_MODE, REF_MODE_RST);
    rd(ADDR_RSVD, RSVD_RST);
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'h00);
    wr(ADDR_RSVD, 8'h06);
    rd(ADDR_RSVD, 8'h06);
    wr(ADDR_EXIT_CFG, 8'h7F);
    rd(ADDR_EXIT_CFG, 8'h7F);
    wait_st(PHC_LOCKED);
    repeat (1500) @(negedge clk_sys);
    `CHK("dac_code", 1'b1, dac_code >= 7'h53 && dac_code <= 7'h56)
    exit_run(8'h10, 8'h00, 0, 8'h4B, 1);
    exit_run(8'h05, 8'h00, 1, 8'h0F, 0);
    exit_run(8'h0C, 8'h04, 2, 8'hCB, 1);
    exit_run(8'h0C, 8'h00, 1, 8'h4B, 1);
    end_of_test();
  end
endmodule
